// [epm_map.vh]
// Constants for the external port pin mux.
// Assumes inclusion by the mux design file only.
`ifndef EPM_MAP_VH
`define EPM_MAP_VH
// Register offsets, byte addresses on APB
`define EPM_OFS_PINCTL   12'h000
`define EPM_OFS_ALTFEAT  12'h004
`define EPM_OFS_RESCFG   12'h008
`define EPM_OFS_STATUS   12'h00c
// Pin control register fields
`define EPM_PC_CTL0      0
`define EPM_PC_CTL1      1
// Alternate feature register fields
`define EPM_AF_SPE       0
`define EPM_AF_SMEM      1
// Resource config register fields
`define EPM_RC_WIDE      0
`define EPM_RC_IRQ_LSB   4
`define EPM_RC_DRQ_LSB   8
// Reset values
`define EPM_RST_PINCTL   2'h0
`define EPM_RST_ALTFEAT  2'h0
`define EPM_RST_RESCFG   1'h0
`define EPM_RST_IRQSEL   3'h0
`define EPM_RST_DRQSEL   2'h0
// Value read from the host port while held in reset
`define EPM_RESET_READ   8'h80
// Nominal clock rates in kHz
`define EPM_CLKA_KHZ     24576
`define EPM_CLKB_KHZ     16934
`endif

// [epm_pin_mux.v]
// External peripheral port glue: strobes, address pins, straps, muxed pins.
// Assumes host bus pins and peripheral pins arrive asynchronous to CLK.
//
// Design decisions made here: the register offsets and the APB slave port.
`include "epm_map.vh"
`timescale 1ns/1ps
`default_nettype none
module epm_pin_mux #(
  parameter SYN_BASE_RST = 16'h0388,
  parameter SYN_MASK     = 16'hfffc,
  parameter CD_MASK      = 16'hfff0
) (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire [11:0] PADDR,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        BUS_RESET_IN,
  input  wire [15:0] HOST_ADDR,
  input  wire        HOST_AEN,
  input  wire        HOST_IOR_N,
  input  wire        HOST_IOW_N,
  input  wire [7:0]  HOST_DATA_IN,
  output reg  [7:0]  HOST_DATA_OUT,
  output reg  [7:0]  HOST_DATA_OE,
  input  wire        HOST_CD_DACK_N,
  output reg  [5:0]  HOST_IRQ,
  output reg  [2:0]  HOST_DRQ,
  output reg         BUFFERED_RESET_N,
  output reg         EXT_READ_STROBE_N,
  output reg         EXT_WRITE_STROBE_N,
  input  wire        EXT_READ_STROBE_IN,
  input  wire        EXT_WRITE_STROBE_IN,
  output reg         SYNTH_SELECT_N,
  output reg         CDROM_SELECT_N,
  output reg         CDROM_DMA_ACK_OUT,
  input  wire        CDROM_IRQ_IN,
  input  wire        CDROM_DMA_REQ_IN,
  output reg  [3:0]  CD_PIN_OUT,
  output reg  [3:0]  CD_PIN_OE,
  output reg         CTL_OUT0_OR_ADDR2,
  output reg         EXT_ADDR_BIT1,
  output reg         EXT_ADDR0_SERIAL_CLOCK,
  input  wire        EXT_DATA0_SERIAL_DATA_IN,
  output reg         EXT_DATA0_SERIAL_DATA_OUT,
  output reg         EXT_DATA0_SERIAL_DATA_OE,
  input  wire [7:1]  EXT_DATA_UPPER_IN,
  output reg  [7:1]  EXT_DATA_UPPER_OUT,
  output reg  [7:1]  EXT_DATA_UPPER_OE,
  input  wire        SHARED_PIN_IN,
  output reg         CONTROL_OUTPUT_ONE,
  output reg         CONTROL_OUTPUT_ONE_OE,
  output reg         SYNTH_IRQ_SEEN,
  output reg         JOYB_X_OR_SERIAL_OUT,
  output reg         JOYB_X_OE,
  input  wire        JOYB_X_IN,
  input  wire        JOYB_Y_OR_SERIAL_IN,
  output reg         JOYB_BTN1_OR_FRAME_SYNC,
  output reg         JOYB_BTN1_OE,
  input  wire        JOYB_BTN1_IN,
  output reg         JOYB_BTN2_OR_SERIAL_CLOCK,
  output reg         JOYB_BTN2_OE,
  input  wire        JOYB_BTN2_IN,
  input  wire        SERIAL_DATA_OUT_SRC,
  input  wire        SERIAL_FRAME_SYNC_SRC,
  input  wire        SERIAL_CLOCK_SRC,
  output reg         SERIAL_DATA_IN_SEEN,
  output reg  [3:0]  JOYB_INPUTS_SEEN,
  input  wire        SMEM_CLOCK_SRC,
  input  wire        SMEM_DATA_LOW_SRC,
  output reg         SMEM_DATA_SEEN
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every asynchronous input
  localparam SW = 46;
  // Reset to each pin's idle level (bus reset, strobes, pull-ups high) so no false edge follows reset
  localparam [SW-1:0] SYNC_IDLE = 46'h2000_0c02_7010;
  wire [SW-1:0] async_in = {BUS_RESET_IN, HOST_ADDR, HOST_AEN, HOST_IOR_N, HOST_IOW_N,
                            HOST_DATA_IN, HOST_CD_DACK_N, CDROM_IRQ_IN, CDROM_DMA_REQ_IN,
                            EXT_READ_STROBE_IN, EXT_WRITE_STROBE_IN, EXT_DATA0_SERIAL_DATA_IN,
                            EXT_DATA_UPPER_IN, SHARED_PIN_IN, JOYB_X_IN, JOYB_Y_OR_SERIAL_IN,
                            JOYB_BTN1_IN, JOYB_BTN2_IN};
  reg  [SW-1:0] meta_r;
  reg  [SW-1:0] sync_r;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_r <= SYNC_IDLE;
      sync_r <= SYNC_IDLE;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  wire        s_buffered_reset_n = sync_r[45];
  wire [15:0] s_addr   = sync_r[44:29];
  wire        s_aen    = sync_r[28];
  wire        s_ior_n  = sync_r[27];
  wire        s_iow_n  = sync_r[26];
  wire [7:0]  s_hdata  = sync_r[25:18];
  wire        s_dack_n = sync_r[17];
  wire        s_cdirq  = sync_r[16];
  wire        s_cddrq  = sync_r[15];
  wire        s_rstrap = sync_r[14];
  wire        s_wstrap = sync_r[13];
  wire        s_xd0    = sync_r[12];
  wire [7:1]  s_xdu    = sync_r[11:5];
  wire        s_shared = sync_r[4];
  wire [3:0]  s_joy    = sync_r[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Straps caught at the falling edge of the synchronised bus reset
  reg buffered_reset_n_d_r;
  reg read_strap_r;
  reg write_strap_r;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      buffered_reset_n_d_r    <= 1'b1;
      read_strap_r  <= 1'b1;
      write_strap_r <= 1'b1;
    end else begin
      buffered_reset_n_d_r <= s_buffered_reset_n;
      if (buffered_reset_n_d_r && !s_buffered_reset_n) begin
        read_strap_r  <= s_rstrap;
        write_strap_r <= s_wstrap;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register file; all but the two base addresses held at reset values while bus reset is high
  reg [1:0]  pinctl_r;
  reg [1:0]  altfeat_r;
  reg        wide_r;
  reg [2:0]  irqsel_r;
  reg [1:0]  drqsel_r;
  reg [15:0] cd_base_r;
  reg [15:0] syn_base_r;
  wire apb_acc = PSEL && PENABLE;
  wire apb_wr  = apb_acc && PWRITE;
  wire mapped = (PADDR == `EPM_OFS_PINCTL) || (PADDR == `EPM_OFS_ALTFEAT) ||
                (PADDR == `EPM_OFS_RESCFG) || (PADDR == `EPM_OFS_STATUS);
  reg [31:0] rdata_nxt;
  always @* begin
    rdata_nxt = 32'h0;
    case (PADDR)
      `EPM_OFS_PINCTL:  rdata_nxt = {30'h0, pinctl_r};
      `EPM_OFS_ALTFEAT: rdata_nxt = {30'h0, altfeat_r};
      `EPM_OFS_RESCFG:  rdata_nxt = {cd_base_r, 4'h0, 2'h0, drqsel_r, 1'b0, irqsel_r, 3'h0, wide_r};
      `EPM_OFS_STATUS:  rdata_nxt = {syn_base_r, 13'h0, s_buffered_reset_n, write_strap_r, read_strap_r};
      default:          rdata_nxt = 32'h0;
    endcase
  end
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pinctl_r   <= `EPM_RST_PINCTL;
      altfeat_r  <= `EPM_RST_ALTFEAT;
      wide_r     <= `EPM_RST_RESCFG;
      irqsel_r   <= `EPM_RST_IRQSEL;
      drqsel_r   <= `EPM_RST_DRQSEL;
      cd_base_r  <= 16'h0;
      syn_base_r <= SYN_BASE_RST;
      PRDATA     <= 32'h0;
      PREADY     <= 1'b0;
      PSLVERR    <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      PRDATA  <= rdata_nxt;
      if (s_buffered_reset_n) begin
        pinctl_r   <= `EPM_RST_PINCTL;
        altfeat_r  <= `EPM_RST_ALTFEAT;
        wide_r     <= `EPM_RST_RESCFG;
        irqsel_r   <= `EPM_RST_IRQSEL;
        drqsel_r   <= `EPM_RST_DRQSEL;
      end else if (apb_wr && PREADY && mapped) begin
        case (PADDR)
          `EPM_OFS_PINCTL:  pinctl_r <= PWDATA[1:0];
          `EPM_OFS_ALTFEAT: altfeat_r <= PWDATA[1:0];
          `EPM_OFS_RESCFG: begin
            wide_r    <= PWDATA[`EPM_RC_WIDE];
            irqsel_r  <= PWDATA[`EPM_RC_IRQ_LSB +: 3];
            drqsel_r  <= PWDATA[`EPM_RC_DRQ_LSB +: 2];
            cd_base_r <= PWDATA[31:16];
          end
          `EPM_OFS_STATUS:  syn_base_r <= PWDATA[31:16];
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and strobes
  wire serial_port_enable   = altfeat_r[`EPM_AF_SPE];
  wire smem  = altfeat_r[`EPM_AF_SMEM];
  wire syn_hit = !s_buffered_reset_n && !s_aen && ((s_addr & SYN_MASK) == (syn_base_r & SYN_MASK));
  wire cd_hit  = !s_buffered_reset_n && !s_aen && !read_strap_r && ((s_addr & CD_MASK) == (cd_base_r & CD_MASK));
  wire any_sel = syn_hit || cd_hit;
  wire rd_act  = any_sel && !s_ior_n;
  wire wr_act  = any_sel && !s_iow_n;

  // Pin drivers, all registered
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUFFERED_RESET_N <= 1'b0;
      EXT_READ_STROBE_N <= 1'b1;
      EXT_WRITE_STROBE_N <= 1'b1;
      SYNTH_SELECT_N <= 1'b1;
      CDROM_SELECT_N <= 1'b1;
      CDROM_DMA_ACK_OUT <= 1'b1;
      HOST_IRQ <= 6'h0;
      HOST_DRQ <= 3'h0;
      CD_PIN_OUT <= 4'h0;
      CD_PIN_OE <= 4'h0;
      CTL_OUT0_OR_ADDR2 <= 1'b0;
      EXT_ADDR_BIT1 <= 1'b0;
      EXT_ADDR0_SERIAL_CLOCK <= 1'b0;
      EXT_DATA0_SERIAL_DATA_OUT <= 1'b0;
      EXT_DATA0_SERIAL_DATA_OE <= 1'b0;
      EXT_DATA_UPPER_OUT <= 7'h0;
      EXT_DATA_UPPER_OE <= 7'h0;
      HOST_DATA_OUT <= 8'h0;
      HOST_DATA_OE <= 8'h0;
      CONTROL_OUTPUT_ONE <= 1'b0;
      CONTROL_OUTPUT_ONE_OE <= 1'b0;
      SYNTH_IRQ_SEEN <= 1'b0;
      JOYB_X_OR_SERIAL_OUT <= 1'b0;
      JOYB_X_OE <= 1'b0;
      JOYB_BTN1_OR_FRAME_SYNC <= 1'b0;
      JOYB_BTN1_OE <= 1'b0;
      JOYB_BTN2_OR_SERIAL_CLOCK <= 1'b0;
      JOYB_BTN2_OE <= 1'b0;
      SERIAL_DATA_IN_SEEN <= 1'b0;
      JOYB_INPUTS_SEEN <= 4'h0;
      SMEM_DATA_SEEN <= 1'b1;
    end else begin
      BUFFERED_RESET_N <= !s_buffered_reset_n;
      EXT_READ_STROBE_N <= !rd_act;
      EXT_WRITE_STROBE_N <= !wr_act;
      SYNTH_SELECT_N <= !syn_hit;
      CDROM_SELECT_N <= !cd_hit;
      CDROM_DMA_ACK_OUT <= s_dack_n || read_strap_r;
      HOST_IRQ <= (cd_hit || !read_strap_r) && s_cdirq && (irqsel_r < 3'h6) ?
                  (6'h01 << irqsel_r) : 6'h00;
      HOST_DRQ <= (!read_strap_r && s_cddrq && (drqsel_r != 2'h3)) ?
                  (3'h1 << drqsel_r) : 3'h0;
      CD_PIN_OUT <= s_addr[15:12];
      CD_PIN_OE <= read_strap_r ? 4'hf : 4'h0;
      CTL_OUT0_OR_ADDR2 <= wide_r ? s_addr[2] : pinctl_r[`EPM_PC_CTL0];
      EXT_ADDR_BIT1 <= s_addr[1];
      EXT_ADDR0_SERIAL_CLOCK <= smem ? SMEM_CLOCK_SRC : s_addr[0];
      // Open drain: only low or released
      EXT_DATA0_SERIAL_DATA_OUT <= 1'b0;
      EXT_DATA0_SERIAL_DATA_OE <= smem ? SMEM_DATA_LOW_SRC :
                                  (wr_act && !s_hdata[0]);
      SMEM_DATA_SEEN <= s_xd0;
      EXT_DATA_UPPER_OUT <= s_hdata[7:1];
      EXT_DATA_UPPER_OE <= wr_act ? 7'h7f : 7'h00;
      HOST_DATA_OUT <= s_buffered_reset_n ? `EPM_RESET_READ : {s_xdu, s_xd0};
      HOST_DATA_OE <= (rd_act || (s_buffered_reset_n && !s_aen && !s_ior_n)) ? 8'hff : 8'h00;
      CONTROL_OUTPUT_ONE <= pinctl_r[`EPM_PC_CTL1];
      CONTROL_OUTPUT_ONE_OE <= write_strap_r;
      SYNTH_IRQ_SEEN <= !write_strap_r && !s_shared;
      JOYB_X_OR_SERIAL_OUT <= SERIAL_DATA_OUT_SRC;
      JOYB_X_OE <= serial_port_enable;
      SERIAL_DATA_IN_SEEN <= serial_port_enable && sync_r[2];
      JOYB_BTN1_OR_FRAME_SYNC <= SERIAL_FRAME_SYNC_SRC;
      JOYB_BTN1_OE <= serial_port_enable;
      JOYB_BTN2_OR_SERIAL_CLOCK <= SERIAL_CLOCK_SRC;
      JOYB_BTN2_OE <= serial_port_enable;
      JOYB_INPUTS_SEEN <= serial_port_enable ? 4'h0 : s_joy;
    end
  end

  // Clock sources are board crystals; this block runs on CLK only
endmodule
`default_nettype wire

// [epm_pin_mux_properties.sv]
// Concurrent checks on the external port pin mux top-level ports.
// Assumes outputs settle within three edges of the raw host inputs.
`timescale 1ns/1ps
`default_nettype none
module epm_pin_mux_properties (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        BUS_RESET_IN,
  input wire logic [15:0] HOST_ADDR,
  input wire logic        HOST_IOR_N,
  input wire logic        HOST_IOW_N,
  input wire logic        HOST_CD_DACK_N,
  input wire logic        BUFFERED_RESET_N,
  input wire logic        EXT_READ_STROBE_N,
  input wire logic        EXT_WRITE_STROBE_N,
  input wire logic        SYNTH_SELECT_N,
  input wire logic        CDROM_SELECT_N,
  input wire logic        CDROM_DMA_ACK_OUT,
  input wire logic [3:0]  CD_PIN_OUT,
  input wire logic [3:0]  CD_PIN_OE,
  input wire logic        EXT_DATA0_SERIAL_DATA_OUT,
  input wire logic [7:1]  EXT_DATA_UPPER_OE,
  input wire logic        JOYB_X_OE,
  input wire logic        JOYB_BTN1_OE,
  input wire logic        JOYB_BTN2_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // Host inputs held long enough to cross the synchronizers
  sequence addr_held;
    $stable(HOST_ADDR)[*6];
  endsequence
  sequence read_held;
    (!HOST_IOR_N && $stable(HOST_ADDR))[*8];
  endsequence
  sequence write_held;
    (!HOST_IOW_N && $stable(HOST_ADDR))[*8];
  endsequence
  ////////////////////////////////////////
  // Pin relations
  reset_drive_a: assert property (BUS_RESET_IN[*4] |-> !BUFFERED_RESET_N)
    else $error("buffered reset not low in bus reset");
  open_drain_a: assert property (EXT_DATA0_SERIAL_DATA_OUT == 1'b0)
    else $error("data bit 0 driven high");
  read_strobe_a: assert property (read_held ##0 !SYNTH_SELECT_N |-> !EXT_READ_STROBE_N)
    else $error("read strobe missing");
  write_strobe_a: assert property (write_held ##0 !SYNTH_SELECT_N |-> !EXT_WRITE_STROBE_N)
    else $error("write strobe missing");
  strobe_idle_a: assert property ((HOST_IOR_N && HOST_IOW_N)[*6] |-> EXT_READ_STROBE_N && EXT_WRITE_STROBE_N)
    else $error("strobe low without host strobe");
  upper_drive_a: assert property (|EXT_DATA_UPPER_OE |-> !EXT_WRITE_STROBE_N)
    else $error("upper data driven outside write");
  joy_group_a: assert property (JOYB_X_OE == JOYB_BTN1_OE && JOYB_BTN1_OE == JOYB_BTN2_OE)
    else $error("joystick B pins disagree");
  cd_addr_a: assert property (addr_held ##0 (|CD_PIN_OE) |-> CD_PIN_OUT == HOST_ADDR[15:12])
    else $error("CD pins not upper address");
  cd_select_a: assert property (|CD_PIN_OE |-> CDROM_SELECT_N)
    else $error("CD select while pins are address");
  dack_pass_a: assert property ((!(|CD_PIN_OE) && $stable(HOST_CD_DACK_N))[*6] |-> CDROM_DMA_ACK_OUT == HOST_CD_DACK_N)
    else $error("DMA acknowledge not forwarded");
  apb_answer_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in access cycle");
endmodule
bind epm_pin_mux epm_pin_mux_properties i_epm_pin_mux_properties (.*);
`default_nettype wire

// [epm_periph_model.sv]
// Far-side peripherals: strap resistors, pulled-up data bit 0, upper data bus.
// Assumes the testbench picks the strap resistors before each bus reset.
`timescale 1ns/1ps
`default_nettype none
module epm_periph_model (
  input  wire logic       clk,
  input  wire logic       rd_strap_low,
  input  wire logic       wr_strap_low,
  input  wire logic       rd_strobe_n,
  input  wire logic       d0_oe,
  output wire logic       rd_pad,
  output wire logic       wr_pad,
  output wire logic       d0_pad,
  output wire logic [7:1] upper
);
  logic [7:1] idle_q = 7'h00;
  // Pull-down resistor dominates the strobe pad when fitted
  assign rd_pad = rd_strobe_n & !rd_strap_low;
  assign wr_pad = !wr_strap_low;
  // Pull-up holds bit 0 high unless the device sinks it
  assign d0_pad = !d0_oe;
  // Peripheral answers a read strobe, otherwise the bus wanders
  always @(posedge clk) begin
    idle_q <= ~idle_q;
  end
  assign upper = !rd_strobe_n ? 7'h5a : idle_q;
endmodule
`default_nettype wire

// [external_port_pin_mux_test.sv]
// Self-checking bench for the external port pin mux.
// Assumes the designer's APB timing and three-edge pin latency.
`timescale 1ns/1ps
`default_nettype none
module external_port_pin_mux_test;
  logic        CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, BUS_RESET_IN = 1;
  logic        HOST_AEN = 0, HOST_IOR_N = 1, HOST_IOW_N = 1, HOST_CD_DACK_N = 1, CDROM_IRQ_IN = 0;
  logic        CDROM_DMA_REQ_IN = 0, SHARED_PIN_IN = 1, JOYB_X_IN = 0, JOYB_Y_OR_SERIAL_IN = 0;
  logic        JOYB_BTN1_IN = 1, JOYB_BTN2_IN = 1, SERIAL_DATA_OUT_SRC = 0, SERIAL_FRAME_SYNC_SRC = 0;
  logic        SERIAL_CLOCK_SRC = 0, SMEM_CLOCK_SRC = 0, SMEM_DATA_LOW_SRC = 0, rd_low = 0, wr_low = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, q;
  logic [15:0] HOST_ADDR = 0;
  logic [7:0]  HOST_DATA_IN = 0;
  logic        err;
  int          bad_count = 0, num_checks = 0;
  wire  [31:0] PRDATA;
  wire  [7:0]  HOST_DATA_OUT, HOST_DATA_OE;
  wire  [5:0]  HOST_IRQ;
  wire  [2:0]  HOST_DRQ;
  wire  [3:0]  CD_PIN_OUT, CD_PIN_OE, JOYB_INPUTS_SEEN;
  wire  [7:1]  EXT_DATA_UPPER_OUT, EXT_DATA_UPPER_OE, EXT_DATA_UPPER_IN;
  wire         PREADY, PSLVERR, BUFFERED_RESET_N, EXT_READ_STROBE_N, EXT_WRITE_STROBE_N, EXT_READ_STROBE_IN;
  wire         EXT_WRITE_STROBE_IN, SYNTH_SELECT_N, CDROM_SELECT_N, CDROM_DMA_ACK_OUT, CTL_OUT0_OR_ADDR2;
  wire         EXT_ADDR_BIT1, EXT_ADDR0_SERIAL_CLOCK, EXT_DATA0_SERIAL_DATA_IN, EXT_DATA0_SERIAL_DATA_OUT;
  wire         EXT_DATA0_SERIAL_DATA_OE, CONTROL_OUTPUT_ONE, CONTROL_OUTPUT_ONE_OE, SYNTH_IRQ_SEEN;
  wire         JOYB_X_OR_SERIAL_OUT, JOYB_X_OE, JOYB_BTN1_OR_FRAME_SYNC, JOYB_BTN1_OE;
  wire         JOYB_BTN2_OR_SERIAL_CLOCK, JOYB_BTN2_OE, SERIAL_DATA_IN_SEEN, SMEM_DATA_SEEN;
  epm_pin_mux i_epm_pin_mux (.*);
  epm_periph_model i_epm_periph_model (.clk(CLK), .rd_strap_low(rd_low), .wr_strap_low(wr_low),
    .rd_strobe_n(EXT_READ_STROBE_N), .d0_oe(EXT_DATA0_SERIAL_DATA_OE), .rd_pad(EXT_READ_STROBE_IN),
    .wr_pad(EXT_WRITE_STROBE_IN), .d0_pad(EXT_DATA0_SERIAL_DATA_IN), .upper(EXT_DATA_UPPER_IN));
  always #5 CLK = ~CLK;
  ////////////////////////////////////////
  // Compare, APB transfer and settle helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK) PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1 && ++n < 50);
    if (n >= 50) bad_count++;
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 0; PENABLE <= 0;
    @(posedge CLK);
  endtask
  task automatic settle;
    repeat (8) @(posedge CLK);
  endtask
  task automatic summarize;
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1;
    apb(1, 12'h000, 32'h3);
    settle;
    chk(BUFFERED_RESET_N, 0);
    HOST_IOR_N <= 0;
    settle;
    chk({HOST_DATA_OE, HOST_DATA_OUT}, 16'hff80);
    HOST_IOR_N <= 1;
    apb(0, 12'h00c, 0); chk(q[2], 1);
    BUS_RESET_IN <= 0;
    HOST_ADDR <= 16'h5006;
    settle;
    apb(0, 12'h00c, 0); chk(q[2:0], 3'h3);
    apb(0, 12'h000, 0); chk(q[1:0], 2'h0);
    chk({BUFFERED_RESET_N, CD_PIN_OE, CONTROL_OUTPUT_ONE_OE}, 6'h3f);
    chk({CD_PIN_OUT, EXT_ADDR_BIT1, EXT_ADDR0_SERIAL_CLOCK, CTL_OUT0_OR_ADDR2}, 7'h2c);
    apb(1, 12'h000, 32'h3);
    settle;
    chk({CTL_OUT0_OR_ADDR2, CONTROL_OUTPUT_ONE}, 2'h3);
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h008, 32'h1);
    settle;
    chk({CTL_OUT0_OR_ADDR2, CONTROL_OUTPUT_ONE}, 2'h2);
    HOST_ADDR <= 16'h038b;
    HOST_IOR_N <= 0;
    settle;
    chk({SYNTH_SELECT_N, EXT_READ_STROBE_N, EXT_WRITE_STROBE_N, EXT_DATA_UPPER_OE}, 10'h080);
    chk({HOST_DATA_OE, HOST_DATA_OUT}, 16'hffb5);
    HOST_AEN <= 1;
    settle;
    chk({SYNTH_SELECT_N, EXT_READ_STROBE_N}, 2'h3);
    HOST_AEN <= 0;
    HOST_IOR_N <= 1;
    HOST_IOW_N <= 0;
    HOST_DATA_IN <= 8'hc6;
    settle;
    chk({EXT_READ_STROBE_N, EXT_WRITE_STROBE_N, EXT_DATA_UPPER_OUT}, 9'h163);
    chk(EXT_DATA0_SERIAL_DATA_OE, 1);
    HOST_IOW_N <= 1;
    HOST_ADDR <= 16'h5006;
    apb(1, 12'h004, 32'h1);
    SERIAL_FRAME_SYNC_SRC <= 1;
    SERIAL_CLOCK_SRC <= 1;
    SERIAL_DATA_OUT_SRC <= 1;
    JOYB_Y_OR_SERIAL_IN <= 1;
    settle;
    chk({JOYB_X_OE, JOYB_X_OR_SERIAL_OUT, JOYB_BTN1_OR_FRAME_SYNC, JOYB_BTN2_OR_SERIAL_CLOCK}, 4'hf);
    chk({SERIAL_DATA_IN_SEEN, JOYB_INPUTS_SEEN}, 5'h10);
    apb(1, 12'h004, 32'h2);
    SMEM_CLOCK_SRC <= 1;
    SMEM_DATA_LOW_SRC <= 1;
    settle;
    chk({JOYB_X_OE, JOYB_BTN1_OE, EXT_ADDR0_SERIAL_CLOCK}, 3'h1);
    chk({SERIAL_DATA_IN_SEEN, JOYB_INPUTS_SEEN}, 5'h07);
    chk({EXT_DATA0_SERIAL_DATA_OE, SMEM_DATA_SEEN}, 2'h2);
    apb(0, 12'h010, 0); chk(err, 1);
    rd_low <= 1;
    wr_low <= 1;
    BUS_RESET_IN <= 1;
    settle;
    BUS_RESET_IN <= 0;
    settle;
    apb(0, 12'h00c, 0); chk(q[2:0], 3'h0);
    chk({CD_PIN_OE, CONTROL_OUTPUT_ONE_OE}, 5'h00);
    apb(1, 12'h008, 32'h0340_0000);
    HOST_ADDR <= 16'h0342;
    HOST_IOR_N <= 0;
    settle;
    chk({CDROM_SELECT_N, EXT_READ_STROBE_N}, 2'h0);
    HOST_IOR_N <= 1;
    SHARED_PIN_IN <= 0;
    CDROM_IRQ_IN <= 1;
    CDROM_DMA_REQ_IN <= 1;
    for (int i = 0; i < 6; i++) begin
      apb(1, 12'h008, ((i % 3) << 8) | (i << 4));
      settle;
      chk({HOST_IRQ, HOST_DRQ}, {6'h1 << i, 3'h1 << (i % 3)});
    end
    chk(SYNTH_IRQ_SEEN, 1);
    HOST_CD_DACK_N <= 0;
    settle;
    chk(CDROM_DMA_ACK_OUT, 0);
    HOST_CD_DACK_N <= 1;
    settle;
    summarize;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge CLK);
    bad_count++;
    summarize;
  end
endmodule
`default_nettype wire
